/* File: design/tag_cfg_pkg.sv */
/*
  Constants for the tag configuration and protection register bank:
  byte addresses, field positions, reset values and contactless command codes.
  Assumes it is compiled before the bank module that imports it.
*/
package tag_cfg_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] WP_LO_ADDR = 12'h800;
  localparam logic [11:0] WP_HI_ADDR = 12'h801;
  localparam logic [11:0] CFG_ADDR = 12'h910;
  localparam logic [11:0] CTRL_ADDR = 12'h920;

  localparam int SECTORS = 16;
  localparam logic [15:0] WP_RESET = 16'h0000;
  // delivery state of the configuration byte
  localparam logic [7:0] CFG_RESET = 8'hF4;

  localparam int CFG_PIN_BIT = 3;
  localparam int CFG_HDO_BIT = 2;
  localparam int CFG_SINK_HI = 1;
  localparam int CFG_SINK_LO = 0;
  localparam logic [7:0] CFG_HARVEST_MASK = 8'h07;
  localparam logic [7:0] CFG_PIN_MASK = 8'h08;

  localparam int CTRL_DONE_BIT = 7;
  localparam int CTRL_FIELD_BIT = 1;
  localparam int CTRL_HEN_BIT = 0;

  typedef enum logic [2:0] {
    CMD_READ_CONFIG = 3'h0,
    CMD_WRITE_HARVEST_CFG = 3'h1,
    CMD_WRITE_PIN_CFG = 3'h2,
    CMD_READ_CONTROL = 3'h3,
    CMD_SET_HARVEST_ENABLE = 3'h4
  } rf_cmd_e;

  typedef enum logic [3:0] {
    PIN_IDLE = 4'h1,
    PIN_RX = 4'h2,
    PIN_EXEC = 4'h4,
    PIN_WIP = 4'h8
  } pin_state_e;
endpackage

/* File: design/tag_config_protect_regs.sv */
/*
  Serial-bus configuration and protection registers of a dual-interface tag:
  sector write-protect map, configuration byte, volatile control register and
  the open-drain activity pin driven from contactless progress events.
  Assumes a serial protocol engine on clk_i that hands over decoded byte
  accesses, and a contactless front end on clk_i that reports frame events.
  The field-present and harvest-power levels are analog, so they are synchronised.
*/
// Contract
// - sixteen write-protect bits, one per sector; 1 blocks serial writes
// - protect map at byte 2048, low byte sectors 7-0, high byte 15-8
// - protect map always readable; writes need the serial password presented
// - activity pin is open drain: pulls low or floats
// - configuration bit 3 picks busy (0) or write-in-progress (1)
// - busy mode: low from start of frame until command execution ends
// - busy mode, faulty command: low only until checksum received
// - held-low pin released at once when field disappears
// - serial bus activity never pulls the activity pin low
// - write mode: low from valid write end until reply begins
// - configuration bit 2 default-off, bits 1-0 sink level
// - control register volatile; bits 7-1 read-only, bit 0 harvest enable
// - harvest output floats unless enabled and power conditions met
// - write done flag cleared at power-on and cycle start, set on success
// - at power-up harvest enable loads inverse of default-off bit
// - control bit 1 shows field present; reads 1 over contactless
// - configuration byte serially readable and writable without password
// - contactless commands read all, write harvest bits, write pin bit
// - configuration writes take effect immediately
// - control register serially accessible; contactless read and set commands
module tag_config_protect_regs
  import tag_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // decoded serial-bus byte access
  input wire logic ser_rd_i,
  input wire logic ser_wr_i,
  input wire logic ser_sel_i,
  input wire logic [ADDR_W-1:0] ser_addr_i,
  input wire logic [7:0] ser_wdata_i,
  input wire logic ser_pwd_ok_i,
  output logic [7:0] ser_rdata_o,
  output logic ser_ack_o,
  output logic ser_nack_o,
  // serial write cycle progress
  input wire logic wr_cycle_start_i,
  input wire logic wr_cycle_ok_i,
  // contactless register commands
  input wire logic rf_cmd_valid_i,
  input wire rf_cmd_e rf_cmd_i,
  input wire logic [7:0] rf_wdata_i,
  output logic [7:0] rf_rdata_o,
  output logic rf_done_o,
  // contactless frame events
  input wire logic rf_sof_i,
  input wire logic rf_crc_done_i,
  input wire logic rf_crc_bad_i,
  input wire logic rf_exec_done_i,
  input wire logic rf_write_end_i,
  input wire logic rf_reply_start_i,
  // analog level indicators, asynchronous
  input wire logic rf_field_i,
  input wire logic harvest_power_ok_i,
  // activity pin, open drain
  output logic rf_activity_o,
  output logic rf_activity_oe_o,
  // harvest output and settings
  output logic harvest_out_en_o,
  output logic [1:0] harvest_sink_level_o,
  output logic [SECTORS-1:0] sector_wp_o
);

  logic [1:0] lvl_meta_ff;
  logic [1:0] lvl_sync_ff;
  logic [15:0] wp_ff;
  logic [7:0] cfg_ff;
  logic hen_ff;
  logic done_ff;
  logic init_ff;
  pin_state_e pin_ff;
  pin_state_e nxt_pin;
  logic [7:0] ser_rdata_ff;
  logic ser_ack_ff;
  logic ser_nack_ff;
  logic [7:0] rf_rdata_ff;
  logic rf_done_ff;

  wire field_on = lvl_sync_ff[0];
  wire power_ok = lvl_sync_ff[1];
  wire wip_mode = cfg_ff[CFG_PIN_BIT];

  // address decode, only with the chip enable select bit set
  wire hit_wp_lo = ser_sel_i && (ser_addr_i == WP_LO_ADDR);
  wire hit_wp_hi = ser_sel_i && (ser_addr_i == WP_HI_ADDR);
  wire hit_cfg = ser_sel_i && (ser_addr_i == CFG_ADDR);
  wire hit_ctrl = ser_sel_i && (ser_addr_i == CTRL_ADDR);
  wire hit_any = hit_wp_lo || hit_wp_hi || hit_cfg || hit_ctrl;
  wire wp_ok = ser_pwd_ok_i;
  wire wr_wp_lo = ser_wr_i && hit_wp_lo && wp_ok;
  wire wr_wp_hi = ser_wr_i && hit_wp_hi && wp_ok;
  wire wr_cfg = ser_wr_i && hit_cfg;
  wire wr_ctrl = ser_wr_i && hit_ctrl;
  wire ser_refused = ser_wr_i && (hit_wp_lo || hit_wp_hi) && !wp_ok;
  wire ser_access = ser_rd_i || ser_wr_i;
  wire ser_good = ser_access && hit_any && !ser_refused;

  wire [7:0] ctrl_view = {done_ff, 5'h00, field_on, hen_ff};
  // contactless view: completion bit not meaningful, field always present
  wire [7:0] ctrl_rf_view = {1'b0, 5'h00, 1'b1, hen_ff};
  wire [7:0] ser_rd_mux = hit_wp_lo ? wp_ff[7:0] :
                          hit_wp_hi ? wp_ff[15:8] :
                          hit_cfg ? cfg_ff :
                          hit_ctrl ? ctrl_view : 8'h00;

  wire rf_wr_hcfg = rf_cmd_valid_i && (rf_cmd_i == CMD_WRITE_HARVEST_CFG);
  wire rf_wr_pcfg = rf_cmd_valid_i && (rf_cmd_i == CMD_WRITE_PIN_CFG);
  wire rf_set_hen = rf_cmd_valid_i && (rf_cmd_i == CMD_SET_HARVEST_ENABLE);
  wire [7:0] rf_rd_mux = (rf_cmd_i == CMD_READ_CONFIG) ? cfg_ff :
                         (rf_cmd_i == CMD_READ_CONTROL) ? ctrl_rf_view : 8'h00;

  // serial write wins when both sides hit the configuration byte together
  wire [7:0] rf_cfg_mask = (rf_wr_hcfg ? CFG_HARVEST_MASK : 8'h00) |
                           (rf_wr_pcfg ? CFG_PIN_MASK : 8'h00);
  wire [7:0] nxt_cfg = wr_cfg ? ser_wdata_i :
                       (cfg_ff & ~rf_cfg_mask) | (rf_wdata_i & rf_cfg_mask);

  // level synchronisers for the two analog indicators
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      lvl_meta_ff <= 2'h0;
      lvl_sync_ff <= 2'h0;
    end
    else
    begin
      lvl_meta_ff <= {harvest_power_ok_i, rf_field_i};
      lvl_sync_ff <= lvl_meta_ff;
    end
  end

  // sector write-protect map
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      wp_ff <= WP_RESET;
    else
    begin
      if (wr_wp_lo)
        wp_ff[7:0] <= ser_wdata_i;
      if (wr_wp_hi)
        wp_ff[15:8] <= ser_wdata_i;
    end
  end

  // reset stands in for the stored non-volatile value
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      cfg_ff <= CFG_RESET;
    else
      cfg_ff <= nxt_cfg;
  end

  // harvest enable is loaded from the stored default one edge after release
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      init_ff <= 1'b0;
      hen_ff <= 1'b0;
    end
    else
    begin
      init_ff <= 1'b1;
      if (!init_ff)
        hen_ff <= ~cfg_ff[CFG_HDO_BIT];
      else if (wr_ctrl)
        hen_ff <= ser_wdata_i[CTRL_HEN_BIT];
      else if (rf_set_hen)
        hen_ff <= rf_wdata_i[CTRL_HEN_BIT];
    end
  end

  // completion flag: a success in the same cycle as a start wins
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      done_ff <= 1'b0;
    else if (wr_cycle_ok_i)
      done_ff <= 1'b1;
    else if (wr_cycle_start_i)
      done_ff <= 1'b0;
  end

  // activity pin sequencing; only contactless events start an indication
  always_comb
  begin
    nxt_pin = pin_ff;
    case (pin_ff)
      PIN_IDLE:
      begin
        if (!wip_mode && rf_sof_i)
          nxt_pin = PIN_RX;
        else if (wip_mode && rf_write_end_i)
          nxt_pin = PIN_WIP;
      end
      PIN_RX:
      begin
        if (rf_crc_done_i && rf_crc_bad_i)
          nxt_pin = PIN_IDLE;
        else if (rf_crc_done_i)
          nxt_pin = PIN_EXEC;
      end
      PIN_EXEC:
      begin
        if (rf_exec_done_i)
          nxt_pin = PIN_IDLE;
      end
      PIN_WIP:
      begin
        if (rf_reply_start_i)
          nxt_pin = PIN_IDLE;
      end
      default:
        nxt_pin = PIN_IDLE;
    endcase
    // a mode change mid-command abandons the old indication
    if (wip_mode != (pin_ff == PIN_WIP) && pin_ff != PIN_IDLE)
      nxt_pin = PIN_IDLE;
    if (!field_on)
      nxt_pin = PIN_IDLE;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      pin_ff <= PIN_IDLE;
    else
      pin_ff <= nxt_pin;
  end

  // bus answers, one cycle after the access
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ser_rdata_ff <= 8'h00;
      ser_ack_ff <= 1'b0;
      ser_nack_ff <= 1'b0;
      rf_rdata_ff <= 8'h00;
      rf_done_ff <= 1'b0;
    end
    else
    begin
      if (ser_rd_i)
        ser_rdata_ff <= ser_rd_mux;
      ser_ack_ff <= ser_good;
      ser_nack_ff <= ser_access && !ser_good;
      if (rf_cmd_valid_i)
        rf_rdata_ff <= rf_rd_mux;
      rf_done_ff <= rf_cmd_valid_i;
    end
  end

  // the pin is only ever driven low; a pull-up outside makes the high level
  assign rf_activity_o = 1'b0;
  // the field check also acts combinationally so the release is immediate
  assign rf_activity_oe_o = (pin_ff != PIN_IDLE) && field_on;
  assign harvest_out_en_o = hen_ff && power_ok && field_on;
  assign harvest_sink_level_o = cfg_ff[CFG_SINK_HI:CFG_SINK_LO];
  assign sector_wp_o = wp_ff;
  assign ser_rdata_o = ser_rdata_ff;
  assign ser_ack_o = ser_ack_ff;
  assign ser_nack_o = ser_nack_ff;
  assign rf_rdata_o = rf_rdata_ff;
  assign rf_done_o = rf_done_ff;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_busy_start;
    pin_ff == PIN_IDLE && !wip_mode && rf_sof_i && field_on;
  endsequence
  sequence s_bad_crc;
    pin_ff == PIN_RX && rf_crc_done_i && rf_crc_bad_i;
  endsequence
  sequence s_wip_start;
    pin_ff == PIN_IDLE && wip_mode && rf_write_end_i && field_on;
  endsequence
  sequence s_busy_end;
    pin_ff == PIN_EXEC && rf_exec_done_i;
  endsequence

  a_busy_pin_low: assert property (s_busy_start ##1 lvl_sync_ff[0] |-> rf_activity_oe_o)
    else $error("busy indication did not start on frame start");
  a_bad_crc_release: assert property (s_bad_crc |=> !rf_activity_oe_o)
    else $error("pin still low after faulty checksum");
  a_wip_pin_low: assert property (s_wip_start ##1 lvl_sync_ff[0] |-> rf_activity_oe_o)
    else $error("write indication did not start");
  // state must drop too, or the pin would snap back low when the field returns
  a_field_loss_release: assert property (!field_on
      |-> !rf_activity_oe_o ##1 pin_ff == PIN_IDLE)
    else $error("pin held low without field");
  a_wp_locked: assert property (ser_wr_i && hit_wp_lo && !ser_pwd_ok_i
      |=> $stable(wp_ff) && ser_nack_o)
    else $error("protect map written without password");
  a_done_flag: assert property (wr_cycle_start_i && !wr_cycle_ok_i
      ##1 !wr_cycle_ok_i [*2] |-> !done_ff)
    else $error("completion flag not cleared at cycle start");
  a_hen_powerup: assert property ($rose(init_ff) |-> hen_ff == ~$past(cfg_ff[CFG_HDO_BIT]))
    else $error("harvest enable not loaded from default");
  a_harvest_off: assert property (!hen_ff |-> !harvest_out_en_o)
    else $error("harvest output active while disabled");
  a_rf_pin_cfg: assert property (rf_wr_pcfg && !wr_cfg
      |=> (cfg_ff & CFG_HARVEST_MASK) == ($past(cfg_ff) & CFG_HARVEST_MASK)
          && cfg_ff[CFG_PIN_BIT] == $past(rf_wdata_i[CFG_PIN_BIT]))
    else $error("pin configuration write touched other bits");
  a_rf_field_read: assert property (rf_cmd_valid_i && rf_cmd_i == CMD_READ_CONTROL
      |=> rf_rdata_o[CTRL_FIELD_BIT] && !rf_rdata_o[CTRL_DONE_BIT])
    else $error("contactless control read wrong field bit");
  a_wp_hi_locked: assert property (ser_wr_i && hit_wp_hi && !ser_pwd_ok_i
      |=> $stable(wp_ff) && ser_nack_o)
    else $error("protect map high byte written without password");
  a_wp_read_open: assert property (ser_rd_i && (hit_wp_lo || hit_wp_hi)
      |=> ser_ack_o && !ser_nack_o)
    else $error("protect map read refused");
  a_cfg_ser_write: assert property (wr_cfg
      |=> cfg_ff == $past(ser_wdata_i) && ser_ack_o)
    else $error("serial configuration write not applied");
  a_ctrl_write: assert property (init_ff && wr_ctrl
      |=> hen_ff == $past(ser_wdata_i[CTRL_HEN_BIT]))
    else $error("serial control write did not reach harvest enable");
  a_ctrl_read_only: assert property (ser_rd_i && hit_ctrl
      |=> ser_rdata_o[CTRL_DONE_BIT-1:CTRL_FIELD_BIT+1] == '0)
    else $error("reserved control bits read nonzero");
  a_harvest_cfg_write: assert property (rf_wr_hcfg && !wr_cfg
      |=> (cfg_ff & CFG_HARVEST_MASK) == ($past(rf_wdata_i) & CFG_HARVEST_MASK)
          && cfg_ff[CFG_PIN_BIT] == $past(cfg_ff[CFG_PIN_BIT]))
    else $error("harvest configuration write wrong");
  a_busy_release: assert property (s_busy_end |=> !rf_activity_oe_o)
    else $error("busy indication outlived execution");
  a_wip_release: assert property (pin_ff == PIN_WIP && rf_reply_start_i
      |=> !rf_activity_oe_o)
    else $error("write indication outlived reply start");
  a_done_set: assert property (wr_cycle_ok_i |=> done_ff)
    else $error("completion flag not set on success");
  a_ser_quiet: assert property (ser_access && pin_ff == PIN_IDLE && !rf_sof_i
      && !rf_write_end_i |=> !rf_activity_oe_o)
    else $error("serial access pulled the activity pin");
endmodule

/* File: bench/ser_master_model.sv */
/*
  Serial bus master stand-in: issues decoded byte reads and writes.
  Assumes the bank registers its ack or nack on the taking edge.
*/
module ser_master_model
  import tag_cfg_pkg::*;
(
  // clock
  input wire logic clk_i,
  // answer from the bank
  input wire logic [7:0] rdata_i,
  input wire logic ack_i,
  input wire logic nack_i,
  // request
  output logic rd_o,
  output logic wr_o,
  output logic sel_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {rd_o, wr_o, sel_o, addr_o, wdata_o} = '0;
  end
  task automatic xfer(input logic wr, input logic sel, input logic [11:0] a,
                      input logic [7:0] d, output logic [1:0] resp, output logic [7:0] q);
    @(posedge clk_i);
    #1;
    rd_o = !wr;
    wr_o = wr;
    sel_o = sel;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    resp = {ack_i, nack_i};
    q = rdata_i;
    {rd_o, wr_o} = 2'b00;
    // idle bus shows inverted leftovers so stale data never looks valid
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule

/* File: bench/tag_config_protect_regs_test.sv */
/*
  Self-checking bench for the tag configuration and protection bank.
  Assumes the bank answers serial and contactless requests one cycle late.
*/
module tag_config_protect_regs_test
  import tag_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, reset_i, pwd, rv, fld, pwr;
  rf_cmd_e cmd;
  logic [7:0] rwd, ev, q;
  logic [1:0] rsp;
  wire logic rd, wr, sel, ack, nack, rdone, act, act_oe, hout;
  wire logic [11:0] addr;
  wire logic [7:0] wd, srd, rrd;
  wire logic [1:0] sink;
  wire logic [15:0] wp;
  // pulled-up pin level
  wire logic act_pin = act_oe ? act : 1'b1;
  int fail_count, total_checks;

  tag_config_protect_regs tag_config_protect_regs_inst (
    .clk_i(clk_i), .reset_i(reset_i), .ser_rd_i(rd), .ser_wr_i(wr),
    .ser_sel_i(sel), .ser_addr_i(addr), .ser_wdata_i(wd), .ser_pwd_ok_i(pwd),
    .ser_rdata_o(srd), .ser_ack_o(ack), .ser_nack_o(nack),
    .wr_cycle_start_i(ev[6]), .wr_cycle_ok_i(ev[7]), .rf_cmd_valid_i(rv),
    .rf_cmd_i(cmd), .rf_wdata_i(rwd), .rf_rdata_o(rrd), .rf_done_o(rdone),
    .rf_sof_i(ev[0]), .rf_crc_done_i(ev[1]), .rf_crc_bad_i(ev[2]),
    .rf_exec_done_i(ev[3]), .rf_write_end_i(ev[4]), .rf_reply_start_i(ev[5]),
    .rf_field_i(fld), .harvest_power_ok_i(pwr), .rf_activity_o(act),
    .rf_activity_oe_o(act_oe), .harvest_out_en_o(hout),
    .harvest_sink_level_o(sink), .sector_wp_o(wp));

  ser_master_model ser_master_model_inst (
    .clk_i(clk_i), .rdata_i(srd), .ack_i(ack), .nack_i(nack), .rd_o(rd),
    .wr_o(wr), .sel_o(sel), .addr_o(addr), .wdata_o(wd));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // read data is only compared on reads; it holds across writes
  task automatic ser(input logic w, input logic s, input logic [11:0] a,
                     input logic [7:0] d, input logic [1:0] er, input logic [7:0] eq);
    ser_master_model_inst.xfer(w, s, a, d, rsp, q);
    chk(rsp, er);
    if (!w)
      chk(q, eq);
  endtask

  task automatic rf(input rf_cmd_e c, input logic [7:0] d, input logic [7:0] eq);
    @(posedge clk_i);
    #1;
    rv = 1'b1;
    cmd = c;
    rwd = d;
    @(posedge clk_i);
    #1;
    rv = 1'b0;
    rwd = ~d;
    chk(rdone, 1'b1);
    chk(rrd, eq);
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge clk_i);
    #1;
    ev = m;
    @(posedge clk_i);
    #1;
    ev = 8'h00;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // full sequence needs under a hundred cycles
  initial
  begin
    #20000;
    fail_count++;
    print_verdict();
  end

  initial
  begin
    {reset_i, pwd, rv, fld, pwr, rwd, ev} = '0;
    reset_i = 1'b1;
    cmd = CMD_READ_CONFIG;
    repeat (3) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    cyc(2);
    chk(wp, WP_RESET);
    ser(1'b0, 1'b1, CFG_ADDR, 8'h00, 2'b10, CFG_RESET);
    ser(1'b0, 1'b1, CTRL_ADDR, 8'h00, 2'b10, 8'h00);
    ser(1'b1, 1'b1, WP_LO_ADDR, 8'hA5, 2'b01, 8'h00);
    chk(wp, 16'h0000);
    pwd = 1'b1;
    ser(1'b1, 1'b1, WP_LO_ADDR, 8'hA5, 2'b10, 8'h00);
    ser(1'b1, 1'b1, WP_HI_ADDR, 8'h3C, 2'b10, 8'h00);
    chk(wp, 16'h3CA5);
    pwd = 1'b0;
    ser(1'b0, 1'b1, WP_HI_ADDR, 8'h00, 2'b10, 8'h3C);
    ser(1'b1, 1'b0, CFG_ADDR, 8'h07, 2'b01, 8'h00);
    ser(1'b0, 1'b1, 12'h911, 8'h00, 2'b01, 8'h00);
    ser(1'b1, 1'b1, CFG_ADDR, 8'h03, 2'b10, 8'h00);
    chk(sink, 2'b11);
    ser(1'b0, 1'b1, CFG_ADDR, 8'h00, 2'b10, 8'h03);
    ser(1'b1, 1'b1, CTRL_ADDR, 8'hFF, 2'b10, 8'h00);
    ser(1'b0, 1'b1, CTRL_ADDR, 8'h00, 2'b10, 8'h01);
    fld = 1'b1;
    pwr = 1'b1;
    cyc(3);
    chk(hout, 1'b1);
    ser(1'b0, 1'b1, CTRL_ADDR, 8'h00, 2'b10, 8'h03);
    pulse(8'h80);
    ser(1'b0, 1'b1, CTRL_ADDR, 8'h00, 2'b10, 8'h83);
    pulse(8'h40);
    ser(1'b0, 1'b1, CTRL_ADDR, 8'h00, 2'b10, 8'h03);
    rf(CMD_SET_HARVEST_ENABLE, 8'h00, 8'h00);
    chk(hout, 1'b0);
    rf(CMD_WRITE_HARVEST_CFG, 8'hFC, 8'h00);
    chk(sink, 2'b00);
    rf(CMD_WRITE_PIN_CFG, 8'hFF, 8'h00);
    rf(CMD_READ_CONFIG, 8'h00, 8'h0C);
    pulse(8'h01);
    chk(act_pin, 1'b1);
    pulse(8'h10);
    chk(act_pin, 1'b0);
    pulse(8'h20);
    chk(act_pin, 1'b1);
    ser(1'b1, 1'b1, CFG_ADDR, 8'h04, 2'b10, 8'h00);
    chk(act_pin, 1'b1);
    pulse(8'h01);
    chk(act_pin, 1'b0);
    pulse(8'h02);
    chk(act_pin, 1'b0);
    pulse(8'h08);
    chk(act_pin, 1'b1);
    pulse(8'h01);
    pulse(8'h06);
    chk(act_pin, 1'b1);
    pulse(8'h01);
    chk(act_pin, 1'b0);
    fld = 1'b0;
    cyc(3);
    chk(act_pin, 1'b1);
    rf(CMD_READ_CONTROL, 8'h00, 8'h02);
    ser(1'b0, 1'b1, CTRL_ADDR, 8'h00, 2'b10, 8'h00);
    print_verdict();
  end
endmodule
